//--- logic/ist_link_edge.sv
// toggles once per rising edge of the external shift clock
`timescale 1ns/10ps
`default_nettype none

module ist_link_edge (
   // link clock and raw reset
   input wire logic  link_clk,
   input wire logic  rst_n,
   // event towards the system domain
   ist_link_if.link  lnk
);

   logic rst_s1_q;
   logic rst_s2_q;
   logic tgl_q;

   // reset brought into the link domain
   always_ff @(posedge link_clk) begin
      rst_s1_q <= rst_n;
      rst_s2_q <= rst_s1_q;
   end

   always_ff @(posedge link_clk) begin
      if (!rst_s2_q) begin
         tgl_q <= 1'b0;
      end else begin
         tgl_q <= ~tgl_q;
      end
   end

   assign lnk.edge_tgl = tgl_q;

endmodule

`default_nettype wire

//--- logic/ist_link_if.sv
// edge event carried from the shift clock domain to the system domain
`timescale 1ns/10ps
`default_nettype none

interface ist_link_if;
   logic edge_tgl;
   modport link (output edge_tgl);
   modport core (input edge_tgl);
endinterface

`default_nettype wire

//--- logic/ist_map.svh
// register offsets, field positions and reset values of the timer and shift block
`ifndef IST_MAP_SVH
`define IST_MAP_SVH

`define IST_OFF_T2_LO   4'h8
`define IST_OFF_T2_HI   4'h9
`define IST_OFF_SR      4'hA
`define IST_OFF_AUX     4'hB

`define IST_ACR_T2_MODE 5
`define IST_ACR_SR_MSB  4
`define IST_ACR_SR_LSB  2

`define IST_ACR_RST     8'h00
`define IST_T2_RST      16'h0000
`define IST_T2_ZERO     16'h0000
`define IST_T2_ALL_ONES 16'hFFFF
`define IST_T2_STEP     16'h0001
`define IST_LAT_RST     8'h00
`define IST_SR_RST      8'h00
`define IST_BYTE_ZERO   8'h00
`define IST_DIV_STEP    8'h01
`define IST_BIT_FIRST   3'h0
`define IST_BIT_LAST    3'h7
`define IST_BIT_STEP    3'h1

`endif

//--- logic/ist_pkg.sv
// types shared by the timer and shift block
package ist_pkg;

   typedef enum logic [2:0] {
      IST_SR_OFF     = 3'b000,
      IST_SR_IN_T2   = 3'b001,
      IST_SR_IN_SYS  = 3'b010,
      IST_SR_IN_EXT  = 3'b011,
      IST_SR_OUT_FREE = 3'b100,
      IST_SR_OUT_T2  = 3'b101,
      IST_SR_OUT_SYS = 3'b110,
      IST_SR_OUT_EXT = 3'b111
   } ist_sr_mode_t;

   typedef enum logic {
      IST_IDLE = 1'b0,
      IST_RUN  = 1'b1
   } ist_run_t;

endpackage

//--- logic/ist_timer_shift.sv
// second interval timer and serial shift register with processor register port
`timescale 1ns/10ps
`default_nettype none
`include "ist_map.svh"

module ist_timer_shift (
   // system
   input  wire logic       MCLK,
   input  wire logic       NRST,
   // processor register port
   input  wire logic       CS1,
   input  wire logic       CS2B,
   input  wire logic       RWB,
   input  wire logic [3:0] RS,
   input  wire logic [7:0] D_IN,
   output logic      [7:0] D_OUT,
   output logic            D_OE,
   // pulse count input
   input  wire logic       PCNT_IN,
   // shift clock line
   input  wire logic       SCLK_IN,
   output logic            SCLK_O,
   output logic            SCLK_OE,
   // shift data line
   input  wire logic       SDATA_I,
   output logic            SDATA_O,
   output logic            SDATA_OE,
   // peripheral control bits for the disabled mode
   input  wire logic       PCTL_CLK_OE,
   input  wire logic       PCTL_CLK_LVL,
   input  wire logic       PCTL_DATA_OE,
   input  wire logic       PCTL_DATA_LVL,
   // flags
   output logic            TIMER_FLAG,
   output logic            SHIFT_FLAG
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic f_is_out(input ist_pkg::ist_sr_mode_t m);
      f_is_out = m[2];
   endfunction

   function automatic logic f_is_ext(input ist_pkg::ist_sr_mode_t m);
      f_is_ext = m[1] & m[0];
   endfunction

   function automatic logic f_is_t2(input ist_pkg::ist_sr_mode_t m);
      f_is_t2 = (m == ist_pkg::IST_SR_IN_T2) || (m == ist_pkg::IST_SR_OUT_FREE)
              || (m == ist_pkg::IST_SR_OUT_T2);
   endfunction

   function automatic logic [7:0] f_rotl(input logic [7:0] v);
      f_rotl = {v[6:0], v[7]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register port decode

   logic [7:0] acr_q;
   logic [7:0] d_out_q;
   logic       d_oe_q;

   wire sel    = CS1 & ~CS2B;
   wire rd     = sel & RWB;
   wire wr     = sel & ~RWB;
   wire hit_lo = (RS == `IST_OFF_T2_LO);
   wire hit_hi = (RS == `IST_OFF_T2_HI);
   wire hit_sr = (RS == `IST_OFF_SR);
   wire hit_ax = (RS == `IST_OFF_AUX);
   wire wr_lo  = wr & hit_lo;
   wire wr_hi  = wr & hit_hi;
   wire rd_lo  = rd & hit_lo;
   wire wr_ax  = wr & hit_ax;
   wire sr_acc = sel & hit_sr;

   ist_pkg::ist_sr_mode_t mode;
   assign mode = ist_pkg::ist_sr_mode_t'(acr_q[`IST_ACR_SR_MSB:`IST_ACR_SR_LSB]);

   wire mode_off = (mode == ist_pkg::IST_SR_OFF);
   wire mode_out = f_is_out(mode);
   wire mode_ext = f_is_ext(mode);
   wire mode_t2  = f_is_t2(mode);
   wire t2_pulse = acr_q[`IST_ACR_T2_MODE];

   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         acr_q <= `IST_ACR_RST;
      end else if (wr_ax) begin
         acr_q <= D_IN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic pcnt_s1_q;
   logic pcnt_s2_q;
   logic pcnt_s3_q;
   logic sdat_s1_q;
   logic sdat_s2_q;
   logic tgl_s1_q;
   logic tgl_s2_q;
   logic tgl_s3_q;

   ist_link_if lnk ();

   ist_link_edge u_link (
      .link_clk (SCLK_IN),
      .rst_n    (NRST),
      .lnk      (lnk.link)
   );

   always_ff @(posedge MCLK) begin
      pcnt_s1_q <= PCNT_IN;
      pcnt_s2_q <= pcnt_s1_q;
      pcnt_s3_q <= pcnt_s2_q;
      sdat_s1_q <= SDATA_I;
      sdat_s2_q <= sdat_s1_q;
      tgl_s1_q  <= lnk.edge_tgl;
      tgl_s2_q  <= tgl_s1_q;
      tgl_s3_q  <= tgl_s2_q;
   end

   wire pcnt_fall = pcnt_s3_q & ~pcnt_s2_q;
   wire ext_evt   = (tgl_s3_q ^ tgl_s2_q) & mode_ext;

   ////////////////////////////////////////////////////////////////////////////
   // second interval timer

   logic [15:0] t2_cnt_q;
   logic [7:0]  t2_lat_q;
   logic        t2_arm_q;
   logic        t2_flag_q;

   wire         t2_dec      = t2_pulse ? pcnt_fall : 1'b1;
   wire         t2_zero_hit = t2_dec & t2_arm_q & (t2_cnt_q == `IST_T2_ZERO);
   wire [15:0]  t2_cnt_d    = wr_hi  ? {D_IN, t2_lat_q} :
                              t2_dec ? t2_cnt_q - `IST_T2_STEP : t2_cnt_q;
   wire         t2_arm_d    = wr_hi | (t2_arm_q & ~t2_zero_hit);
   wire         t2_flag_d   = t2_zero_hit | (t2_flag_q & ~(rd_lo | wr_hi));

   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         t2_cnt_q  <= `IST_T2_RST;
         t2_lat_q  <= `IST_LAT_RST;
         t2_arm_q  <= 1'b0;
         t2_flag_q <= 1'b0;
      end else begin
         t2_cnt_q  <= t2_cnt_d;
         t2_lat_q  <= wr_lo ? D_IN : t2_lat_q;
         t2_arm_q  <= t2_arm_d;
         t2_flag_q <= t2_flag_d;
      end
   end

   assign TIMER_FLAG = t2_flag_q;

   ////////////////////////////////////////////////////////////////////////////
   // shift register

   logic [7:0]          sr_q;
   logic [7:0]          sr_d;
   logic [2:0]          bit_q;
   logic [2:0]          bit_d;
   logic [7:0]          div_q;
   logic                sclk_q;
   logic                sclk_d;
   logic                out_q;
   logic                out_d;
   logic                pend_q;
   logic                pend_d;
   logic                sr_flag_q;
   logic                sr_set;
   ist_pkg::ist_run_t   run_q;
   ist_pkg::ist_run_t   run_d;

   wire       div_zero = (div_q == `IST_BYTE_ZERO);
   wire [7:0] div_d    = (sr_acc || (run_q == ist_pkg::IST_RUN && div_zero)) ? t2_lat_q
                                                              : div_q - `IST_DIV_STEP;
   wire       int_tick = (run_q == ist_pkg::IST_RUN) & ~pend_q & ~mode_off & ~mode_ext
                       & (mode_t2 ? div_zero : 1'b1);
   wire       bit_last = (bit_q == `IST_BIT_LAST);
   wire       sr_flag_d = ~mode_off & (sr_set | (sr_flag_q & ~sr_acc));

   always_comb begin
      sr_d   = sr_q;
      bit_d  = bit_q;
      sclk_d = sclk_q;
      out_d  = out_q;
      pend_d = 1'b0;
      run_d  = run_q;
      sr_set = 1'b0;
      if (sr_acc) begin
         bit_d  = `IST_BIT_FIRST;
         sclk_d = 1'b1;
         run_d  = (mode_off || mode_ext) ? ist_pkg::IST_IDLE : ist_pkg::IST_RUN;
         if (wr) begin
            sr_d  = D_IN;
            out_d = (mode_ext && mode_out) ? D_IN[7] : out_q;
         end
      end else if (ext_evt) begin
         bit_d  = bit_q + `IST_BIT_STEP;
         sr_set = bit_last;
         if (mode_out) begin
            sr_d  = f_rotl(sr_q);
            out_d = sr_q[6];
         end else begin
            sr_d = {sr_q[6:0], sdat_s2_q};
         end
      end else if (pend_q) begin
         sr_d  = {sr_q[6:0], sdat_s2_q};
         bit_d = bit_q + `IST_BIT_STEP;
         if (bit_last) begin
            sr_set = 1'b1;
            run_d  = ist_pkg::IST_IDLE;
         end
      end else if (int_tick) begin
         if (sclk_q) begin
            sclk_d = 1'b0;
            if (mode_out) begin
               sr_d  = f_rotl(sr_q);
               out_d = sr_q[7];
            end
         end else begin
            sclk_d = 1'b1;
            if (!mode_out) begin
               pend_d = 1'b1;
            end else if (mode != ist_pkg::IST_SR_OUT_FREE) begin
               bit_d = bit_q + `IST_BIT_STEP;
               if (bit_last) begin
                  sr_set = 1'b1;
                  run_d  = ist_pkg::IST_IDLE;
               end
            end
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         sr_q      <= `IST_SR_RST;
         bit_q     <= `IST_BIT_FIRST;
         div_q     <= `IST_LAT_RST;
         sclk_q    <= 1'b1;
         out_q     <= 1'b0;
         pend_q    <= 1'b0;
         run_q     <= ist_pkg::IST_IDLE;
         sr_flag_q <= 1'b0;
      end else begin
         sr_q      <= sr_d;
         bit_q     <= bit_d;
         div_q     <= div_d;
         sclk_q    <= sclk_d;
         out_q     <= out_d;
         pend_q    <= pend_d;
         run_q     <= run_d;
         sr_flag_q <= sr_flag_d;
      end
   end

   assign SHIFT_FLAG = sr_flag_q;
   assign SCLK_O     = mode_off ? PCTL_CLK_LVL  : sclk_q;
   assign SCLK_OE    = mode_off ? PCTL_CLK_OE   : ~mode_ext;
   assign SDATA_O    = mode_off ? PCTL_DATA_LVL : out_q;
   assign SDATA_OE   = mode_off ? PCTL_DATA_OE  : mode_out;

   ////////////////////////////////////////////////////////////////////////////
   // read data

   wire [7:0] rdata = hit_lo ? t2_cnt_q[7:0] :
                      hit_hi ? t2_cnt_q[15:8] :
                      hit_sr ? sr_q :
                      hit_ax ? acr_q : `IST_BYTE_ZERO;

   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         d_out_q <= `IST_BYTE_ZERO;
         d_oe_q  <= 1'b0;
      end else begin
         d_out_q <= rd ? rdata : `IST_BYTE_ZERO;
         d_oe_q  <= rd;
      end
   end

   assign D_OUT = d_out_q;
   assign D_OE  = d_oe_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!NRST);

   t2_load_a: assert property (wr_hi |=> t2_cnt_q == {$past(D_IN), $past(t2_lat_q)} && t2_arm_q)
      else $error("high write did not load the counter");
   lat_only_a: assert property (wr_lo && !t2_pulse |=> t2_lat_q == $past(D_IN) && t2_cnt_q == $past(t2_cnt_q) - `IST_T2_STEP)
      else $error("low write disturbed the counter");
   interval_dec_a: assert property (!t2_pulse && !wr_hi ##1 !t2_pulse && !wr_hi
      |=> t2_cnt_q == $past(t2_cnt_q, 2) - 16'h0002)
      else $error("interval counter did not decrement per cycle");
   zero_wrap_a: assert property (t2_zero_hit && !wr_hi |=> TIMER_FLAG && !t2_arm_q && t2_cnt_q == `IST_T2_ALL_ONES)
      else $error("zero count did not set flag and wrap");
   lo_read_a: assert property (rd_lo && !t2_zero_hit |=> !TIMER_FLAG)
      else $error("low read did not clear the timer flag");
   disarm_a: assert property (!t2_arm_q && !TIMER_FLAG && !wr_hi |=> !TIMER_FLAG)
      else $error("disarmed timer raised its flag");
   pulse_hold_a: assert property (t2_pulse && !pcnt_fall && !wr_hi |=> $stable(t2_cnt_q))
      else $error("pulse counter moved without a pulse");
   off_flag_a: assert property (mode_off && !wr_ax |=> !SHIFT_FLAG && $stable(sr_q) || $past(wr))
      else $error("disabled shift register shifted or flagged");
   rotate_out_a: assert property (int_tick && sclk_q && mode_out && !sr_acc |=> sr_q == {$past(sr_q[6:0]), $past(sr_q[7])} && SDATA_O == $past(sr_q[7]))
      else $error("shift out did not rotate msb");
   shift_in_a: assert property (pend_q && !sr_acc |=> sr_q == {$past(sr_q[6:0]), $past(sdat_s2_q)})
      else $error("shift in did not enter at lsb");
   free_run_a: assert property (mode == ist_pkg::IST_SR_OUT_FREE |-> !sr_set)
      else $error("free running mode raised the shift flag");
   ext_eight_a: assert property (ext_evt && bit_last && !sr_acc && !wr_ax |=> SHIFT_FLAG && bit_q == `IST_BIT_FIRST)
      else $error("external eighth pulse did not flag");
   int_stop_a: assert property (sr_set && !mode_ext && !sr_acc |=> run_q == ist_pkg::IST_IDLE && sclk_q)
      else $error("internal shifting did not stop after eight");

endmodule

`default_nettype wire

//--- verif/ist_serial_peer.sv
// serial peripheral model on the shift clock and shift data lines
`timescale 1ns/10ps
`default_nettype none

module ist_serial_peer (
   // resolved lines and device drive state
   input  wire logic       sclk_line,
   input  wire logic       sdata_line,
   input  wire logic       dev_clk_oe,
   input  wire logic       dev_data_oe,
   // peer drive
   output logic            sclk_out,
   output logic            sdata_out,
   // observed traffic
   output logic      [7:0] rx_byte,
   output int              rises
);
   logic [7:0] sh;
   logic       pend;

   initial begin
      sclk_out = 1'b0;
      sdata_out = 1'b0;
      rx_byte = 8'h00;
      rises = 0;
      sh = 8'h00;
      pend = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // capture device output on its own clock rises
   always @(posedge sclk_line) begin
      if (dev_clk_oe === 1'b1) begin
         rises = rises + 1;
         pend = 1'b1;
         if (dev_data_oe === 1'b1) begin
            rx_byte = {rx_byte[6:0], sdata_line};
         end
      end
   end

   // next input bit only after the fall
   always @(negedge sclk_line) begin
      if (dev_clk_oe === 1'b1 && pend) begin
         sh = {sh[6:0], sh[7]};
         sdata_out = sh[7];
         pend = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic load(input logic [7:0] b);
      sh = b;
      sdata_out = b[7];
      pend = 1'b0;
   endtask

   // link clock bursts, clock still between them
   task automatic send_ext(input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         if (dev_data_oe === 1'b1) begin
            rx_byte = {rx_byte[6:0], sdata_line};
         end
         sclk_out = 1'b1;
         #3;
         sclk_out = 1'b0;
         #3;
         #(gap);
         if (dev_data_oe !== 1'b1) begin
            sh = {sh[6:0], sh[7]};
            sdata_out = sh[7];
         end
         #(gap);
      end
   endtask
endmodule

`default_nettype wire

//--- verif/ist_timer_shift_test.sv
// self-checking bench for the timer and shift block
`timescale 1ns/10ps
`default_nettype none

module ist_timer_shift_test;
   logic       MCLK, NRST, CS1, CS2B, RWB, PCNT_IN, D_OE, TIMER_FLAG, SHIFT_FLAG;
   logic [3:0] RS;
   logic [7:0] D_IN, D_OUT, got, rxv;
   logic       SCLK_O, SCLK_OE, SDATA_O, SDATA_OE, peer_clk, peer_data;
   logic       PCTL_CLK_OE, PCTL_CLK_LVL, PCTL_DATA_OE, PCTL_DATA_LVL;
   wire        sclk_line, sdata_line;
   int         failures, samples_checked, rises, r0;
   logic [2:0] modes [4];
   logic [7:0] bytes [4];

   assign sclk_line = SCLK_OE ? SCLK_O : peer_clk;
   assign sdata_line = SDATA_OE ? SDATA_O : peer_data;
   always #50 MCLK = ~MCLK;

   ist_timer_shift u_dut (.MCLK(MCLK), .NRST(NRST), .CS1(CS1), .CS2B(CS2B), .RWB(RWB),
      .RS(RS), .D_IN(D_IN), .D_OUT(D_OUT), .D_OE(D_OE), .PCNT_IN(PCNT_IN),
      .SCLK_IN(sclk_line), .SCLK_O(SCLK_O), .SCLK_OE(SCLK_OE), .SDATA_I(sdata_line),
      .SDATA_O(SDATA_O), .SDATA_OE(SDATA_OE), .PCTL_CLK_OE(PCTL_CLK_OE),
      .PCTL_CLK_LVL(PCTL_CLK_LVL), .PCTL_DATA_OE(PCTL_DATA_OE),
      .PCTL_DATA_LVL(PCTL_DATA_LVL), .TIMER_FLAG(TIMER_FLAG), .SHIFT_FLAG(SHIFT_FLAG));

   ist_serial_peer u_peer (.sclk_line(sclk_line), .sdata_line(sdata_line),
      .dev_clk_oe(SCLK_OE), .dev_data_oe(SDATA_OE), .sclk_out(peer_clk),
      .sdata_out(peer_data), .rx_byte(rxv), .rises(rises));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chkf(input logic g, input logic e);
      chk8({7'h00, g}, {7'h00, e});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge MCLK);
      #1;
   endtask

   // one selected cycle, read answer the cycle after
   task automatic acc(input logic rd, input logic [3:0] a, input logic [7:0] d);
      @(posedge MCLK);
      CS1 <= 1'b1;
      RWB <= rd;
      RS <= a;
      D_IN <= d;
      @(posedge MCLK);
      CS1 <= 1'b0;
      #1;
      got = D_OUT;
      if (rd) begin
         chkf(D_OE, 1'b1);
      end
   endtask

   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      acc(1'b1, a, 8'h00);
      chk8(got, e);
   endtask

   task automatic wait_flag(input logic shf, input int bound);
      for (int i = 0; i < bound; i++) begin
         cyc(1);
         if ((shf ? SHIFT_FLAG : TIMER_FLAG) === 1'b1) begin
            return;
         end
      end
      failures++;
      complete_run();
   endtask

   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge MCLK);
         PCNT_IN <= 1'b0;
         repeat (3) @(posedge MCLK);
         PCNT_IN <= 1'b1;
         cyc(3);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      MCLK = 1'b0;
      NRST = 1'b0;
      CS1 = 1'b0;
      CS2B = 1'b0;
      RWB = 1'b1;
      RS = 4'h0;
      D_IN = 8'h00;
      PCNT_IN = 1'b1;
      PCTL_CLK_OE = 1'b0;
      PCTL_CLK_LVL = 1'b0;
      PCTL_DATA_OE = 1'b0;
      PCTL_DATA_LVL = 1'b0;
      failures = 0;
      samples_checked = 0;
      modes = '{3'b101, 3'b110, 3'b001, 3'b010};
      bytes = '{8'hA5, 8'h3C, 8'hC6, 8'hFF};
      #10;
      u_peer.send_ext(4, 0);
      cyc(4);
      NRST <= 1'b1;
      PCTL_CLK_OE <= 1'b1;
      PCTL_CLK_LVL <= 1'b1;
      PCTL_DATA_OE <= 1'b1;
      cyc(2);
      chkf(SCLK_O & SCLK_OE & SDATA_OE & ~SDATA_O, 1'b1);
      acc(1'b0, 4'hA, 8'h4B);
      rdc(4'hA, 8'h4B);
      chkf(SHIFT_FLAG, 1'b0);
      rdc(4'h3, 8'h00);
      acc(1'b0, 4'h8, 8'h10);
      PCTL_CLK_OE <= 1'b0;
      PCTL_DATA_OE <= 1'b0;
      acc(1'b0, 4'h9, 8'h00);
      cyc(8);
      chkf(TIMER_FLAG, 1'b0);
      wait_flag(1'b0, 30);
      rdc(4'h9, 8'hFF);
      chkf(TIMER_FLAG, 1'b1);
      acc(1'b1, 4'h8, 8'h00);
      chkf(TIMER_FLAG, 1'b0);
      cyc(66000);
      chkf(TIMER_FLAG, 1'b0);
      acc(1'b0, 4'hB, 8'h20);
      rdc(4'hB, 8'h20);
      acc(1'b0, 4'h8, 8'h03);
      acc(1'b0, 4'h9, 8'h00);
      acc(1'b0, 4'h8, 8'h77);
      rdc(4'h8, 8'h03);
      pulse(3);
      rdc(4'h8, 8'h00);
      chkf(TIMER_FLAG, 1'b0);
      pulse(1);
      chkf(TIMER_FLAG, 1'b1);
      rdc(4'h9, 8'hFF);
      acc(1'b0, 4'h8, 8'h07);
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, 4'hB, {3'b000, modes[i], 2'b00});
         cyc(300);
         r0 = rises;
         u_peer.load(bytes[i]);
         acc(1'b0, 4'hA, modes[i][2] ? bytes[i] : ~bytes[i]);
         wait_flag(1'b1, 400);
         cyc(20);
         chk8(8'(rises - r0), 8'h08);
         if (modes[i][2]) begin
            chk8(rxv, bytes[i]);
         end
         rdc(4'hA, bytes[i]);
         chkf(SHIFT_FLAG, 1'b0);
      end
      acc(1'b0, 4'hB, 8'h10);
      cyc(2);
      r0 = rises;
      acc(1'b0, 4'hA, 8'h81);
      cyc(400);
      chkf(SHIFT_FLAG, 1'b0);
      chkf((rises - r0) > 16, 1'b1);
      chkf(rxv inside {8'h81, 8'h03, 8'h06, 8'h0C, 8'h18, 8'h30, 8'h60, 8'hC0}, 1'b1);
      acc(1'b0, 4'hB, 8'h0C);
      cyc(8);
      u_peer.load(8'h5A);
      acc(1'b0, 4'hA, 8'h00);
      u_peer.send_ext(8, 500);
      cyc(6);
      chkf(SHIFT_FLAG, 1'b1);
      rdc(4'hA, 8'h5A);
      chkf(SHIFT_FLAG, 1'b0);
      u_peer.send_ext(8, 500);
      cyc(6);
      chkf(SHIFT_FLAG, 1'b1);
      acc(1'b0, 4'hB, 8'h1C);
      acc(1'b0, 4'hA, 8'h96);
      u_peer.send_ext(8, 500);
      cyc(6);
      chk8(rxv, 8'h96);
      chkf(SHIFT_FLAG, 1'b1);
      complete_run();
   end
endmodule

`default_nettype wire
